// ---- hdl/pmbc_top.sv ----
// power mode controller with boost converter control
//
// The address-and-strobe port and the register addresses were left to the implementer.
`include "pmbc_cfg.svh"
module pmbc_top (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic periph_irq,
  input wire logic supervisor_irq,
  input wire logic pin_irq,
  input wire logic external_reset_pin_n,
  input wire logic watchdog_reset_source,
  input wire logic precise_low_voltage_reset,
  input wire logic [7:0] gpio_out_in,
  output logic [7:0] gpio_out,
  output logic [7:0] res_enable,
  output logic [7:0] res_clk_en,
  output pmbc_pkg::pmbc_mode_t power_mode,
  output logic boost_active,
  output logic [5:0] boost_vsel,
  output logic boost_sw,
  output logic timewheel_irq
);
  import pmbc_pkg::*;

  localparam int SLEEP_CYC = `PMBC_SLEEP_CYC;
  localparam int HIB_CYC = `PMBC_HIB_CYC;

  ////////////////////////////////////////////////////////////////////////////
  // reset release and pin synchronisers

  logic rst_s1;
  logic rst_sync_n;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_s1 <= 1'b0;
      rst_sync_n <= 1'b0;
    end
    else
    begin
      rst_s1 <= 1'b1;
      rst_sync_n <= rst_s1;
    end
  end

  // pins are asynchronous, two stages each
  logic [5:0] pin_s1;
  logic [5:0] pin_s2;
  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      pin_s1 <= 6'h01;
      pin_s2 <= 6'h01;
    end
    else
    begin
      pin_s1 <= {periph_irq, supervisor_irq, pin_irq, watchdog_reset_source,
                 precise_low_voltage_reset, external_reset_pin_n};
      pin_s2 <= pin_s1;
    end
  end
  logic [7:0] gpio_s1;
  logic [7:0] gpio_s2;
  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      gpio_s1 <= 8'h00;
      gpio_s2 <= 8'h00;
    end
    else
    begin
      gpio_s1 <= gpio_out_in;
      gpio_s2 <= gpio_s1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  pmbc_tpl_t tpl_act;
  pmbc_tpl_t tpl_alt;
  logic [3:0] wake_en;
  logic [5:0] vsel;
  logic boost_stby;
  logic [15:0] tw_period;
  logic cpu_clear;

  wire wr_mode = reg_wr && reg_addr == `PMBC_OFF_MODE;

  // software writes; templates change at any time
  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      tpl_act <= `PMBC_RST_TPL_ACT;
      tpl_alt <= `PMBC_RST_TPL_ALT;
      wake_en <= `PMBC_RST_WAKE_EN;
      vsel <= `PMBC_RST_VSEL;
      boost_stby <= 1'b0;
      tw_period <= `PMBC_RST_TW;
    end
    else
    begin
      if (reg_wr)
      begin
        unique case (reg_addr)
          `PMBC_OFF_TPL_ACT: tpl_act <= reg_wdata[7:0];
          `PMBC_OFF_TPL_ALT: tpl_alt <= reg_wdata[7:0];
          `PMBC_OFF_WAKE_EN: wake_en <= reg_wdata[3:0];
          `PMBC_OFF_BOOST:
          begin
            // clamp above 5.0 V; code n gives 1.8 V + n * 100 mV
            vsel <= (reg_wdata[5:0] > `PMBC_VSEL_MAX) ? `PMBC_VSEL_MAX : reg_wdata[5:0];
            boost_stby <= reg_wdata[8];
          end
          `PMBC_OFF_TW: tw_period <= reg_wdata;
          default: ;
        endcase
      end
      if (cpu_clear)
        tpl_act[`PMBC_CPU_BIT] <= 1'b1;
    end
  end

  // read data one cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      reg_rdata <= 16'h0000;
    else if (reg_rd)
    begin
      unique case (reg_addr)
        `PMBC_OFF_MODE: reg_rdata <= {12'h000, power_mode};
        `PMBC_OFF_TPL_ACT: reg_rdata <= {8'h00, tpl_act};
        `PMBC_OFF_TPL_ALT: reg_rdata <= {8'h00, tpl_alt};
        `PMBC_OFF_WAKE_EN: reg_rdata <= {12'h000, wake_en};
        `PMBC_OFF_BOOST: reg_rdata <= {7'h00, boost_stby, 2'h0, vsel};
        `PMBC_OFF_STATUS: reg_rdata <= {8'h00, res_enable};
        `PMBC_OFF_TW: reg_rdata <= tw_period;
        default: reg_rdata <= 16'h0000;
      endcase
    end
    else
      reg_rdata <= 16'h0000;
  end

  ////////////////////////////////////////////////////////////////////////////
  // timewheel

  logic [15:0] tw_cnt;
  logic tw_event;
  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      tw_cnt <= 16'h0000;
      tw_event <= 1'b0;
    end
    else if (tw_cnt >= tw_period)
    begin
      tw_cnt <= 16'h0000;
      tw_event <= 1'b1;
    end
    else
    begin
      tw_cnt <= tw_cnt + 16'h0001;
      tw_event <= 1'b0;
    end
  end
  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      timewheel_irq <= 1'b0;
    else
      timewheel_irq <= tw_event && wake_en[3];
  end

  ////////////////////////////////////////////////////////////////////////////
  // wakeup sources

  // bits: ext reset (low), precise reset, watchdog, pin, supervisor, periph
  wire reset_wake = !pin_s2[0] || pin_s2[1] || pin_s2[2];
  wire pin_wake = pin_s2[3] && wake_en[2];
  wire irq_wake = pin_wake || (pin_s2[4] && wake_en[1]) || (pin_s2[5] && wake_en[0]) ||
                  (tw_event && wake_en[3]);
  wire any_wake = reset_wake || irq_wake;

  ////////////////////////////////////////////////////////////////////////////
  // mode state machine

  typedef enum logic [3:0] {
    ST_RUN = 4'h1,
    ST_SLEEP = 4'h2,
    ST_HIB = 4'h4,
    ST_RESUME = 4'h8
  } pmbc_st_t;
  pmbc_st_t st;
  logic [15:0] resume_cnt;

  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      st <= ST_RUN;
      power_mode <= PMBC_MODE_ACTIVE;
      resume_cnt <= 16'h0000;
      cpu_clear <= 1'b0;
    end
    else
    begin
      cpu_clear <= 1'b0;
      unique case (st)
        ST_RUN:
        begin
          if (any_wake)
          begin
            power_mode <= PMBC_MODE_ACTIVE;
            cpu_clear <= 1'b1;
          end
          else if (wr_mode)
          begin
            // only a software write enters low power
            unique case (reg_wdata[1:0])
              2'h0: power_mode <= PMBC_MODE_ACTIVE;
              2'h1: power_mode <= PMBC_MODE_ALT;
              2'h2:
              begin
                power_mode <= PMBC_MODE_SLEEP;
                st <= ST_SLEEP;
              end
              default:
              begin
                power_mode <= PMBC_MODE_HIB;
                st <= ST_HIB;
              end
            endcase
          end
        end
        ST_SLEEP:
          if (any_wake)
          begin
            resume_cnt <= 16'(SLEEP_CYC - 1);
            st <= ST_RESUME;
          end
        ST_HIB:
          // only the pin interrupt or the reset pin leave hibernate
          if (pin_wake || !pin_s2[0])
          begin
            resume_cnt <= 16'(HIB_CYC - 1);
            st <= ST_RESUME;
          end
        ST_RESUME:
          if (resume_cnt == 16'h0000)
          begin
            st <= ST_RUN;
            power_mode <= PMBC_MODE_ACTIVE;
            cpu_clear <= 1'b1;
          end
          else
            resume_cnt <= resume_cnt - 16'h0001;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // resource enables and clock gates

  pmbc_tpl_t next_enable;
  always_comb
  begin
    next_enable = 8'h00;
    if (st == ST_RUN && power_mode == PMBC_MODE_ALT)
      next_enable = tpl_alt;
    else if (st == ST_RUN)
      next_enable = tpl_act;
    else if (st == ST_SLEEP)
      next_enable = `PMBC_SLEEP_KEEP;
    if (cpu_clear)
      next_enable[`PMBC_CPU_BIT] = 1'b1;
  end

  // registered enables; clock gate follows the enable so a glitch-free cell can use it
  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      res_enable <= `PMBC_RST_TPL_ACT;
      res_clk_en <= `PMBC_RST_TPL_ACT;
    end
    else
    begin
      res_enable <= next_enable;
      res_clk_en <= next_enable;
    end
  end

  // output pins hold their level until the hibernate resume is over
  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      gpio_out <= 8'h00;
    else if (power_mode != PMBC_MODE_HIB)
      gpio_out <= gpio_s2;
  end

  ////////////////////////////////////////////////////////////////////////////
  // boost control

  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      boost_active <= 1'b1;
      boost_vsel <= `PMBC_RST_VSEL;
    end
    else
    begin
      boost_active <= !boost_stby;
      boost_vsel <= vsel;
    end
  end

  pmbc_boost_osc u_osc (
    .clk(clk),
    .rst_n(rst_sync_n),
    .run(boost_active),
    .sw(boost_sw)
  );
endmodule

// ---- hdl/pmbc_cfg.svh ----
// constants for the power mode and boost controller
// Operation
// - in active mode each resource follows its active template bit, writable anytime
// - clocks of disabled resources are gated off
// - processor may disable itself; next wakeup re-enables it
// - any wakeup sets mode active and enables processor regardless of template
// - mode defaults to active after boot
// - alternate active mode applies its own separate template
// - leaving sleep waits about 15 us resume before active
// - hibernate retains state, holds output pins, keeps pin interrupt settings
// - hibernate exits only on pin interrupt, resume under 100 us (code also exits on the external reset pin)
// - enabled peripheral, supervisor, timewheel and pin interrupts wake to active
// - external reset pin, watchdog and precise low-voltage reset also wake
// - periodic timewheel interrupt can wake the system
// - boost output selectable 1.8 V to 5.0 V in 100 mV steps
// - boost switches at 400 kHz from its own oscillator (code divides the system clock)
// - boost has active and standby modes
// - separate template register per mode (code has them for active and alternate active only)
// - sleep disables most resources regardless of template
`ifndef PMBC_CFG_SVH
`define PMBC_CFG_SVH
`define PMBC_NRES 8
`define PMBC_CPU_BIT 0
`define PMBC_SLEEP_KEEP 8'h80
`define PMBC_OFF_MODE 4'h0
`define PMBC_OFF_TPL_ACT 4'h1
`define PMBC_OFF_TPL_ALT 4'h2
`define PMBC_OFF_WAKE_EN 4'h3
`define PMBC_OFF_BOOST 4'h4
`define PMBC_OFF_STATUS 4'h5
`define PMBC_OFF_TW 4'h6
`define PMBC_RST_TPL_ACT 8'hff
`define PMBC_RST_TPL_ALT 8'hfe
`define PMBC_RST_WAKE_EN 4'hf
`define PMBC_RST_VSEL 6'h00
`define PMBC_VSEL_MAX 6'h20
`define PMBC_RST_TW 16'h0fff
`define PMBC_CLK_MHZ 200
`define PMBC_SLEEP_RESUME_NS 15000
`define PMBC_HIB_RESUME_NS 100000
`define PMBC_SLEEP_CYC ((`PMBC_SLEEP_RESUME_NS * `PMBC_CLK_MHZ) / 1000)
`define PMBC_HIB_CYC (((`PMBC_HIB_RESUME_NS * `PMBC_CLK_MHZ) / 1000) - 1)
`define PMBC_BOOST_KHZ 400
`define PMBC_BOOST_DIV ((`PMBC_CLK_MHZ * 1000) / (`PMBC_BOOST_KHZ * 2))
`endif

// ---- hdl/pmbc_pkg.sv ----
// types for the power mode and boost controller
package pmbc_pkg;
  typedef enum logic [3:0] {
    PMBC_MODE_ACTIVE = 4'h1,
    PMBC_MODE_ALT = 4'h2,
    PMBC_MODE_SLEEP = 4'h4,
    PMBC_MODE_HIB = 4'h8
  } pmbc_mode_t;
  typedef logic [7:0] pmbc_tpl_t;
endpackage

// ---- hdl/pmbc_boost_osc.sv ----
// boost switching oscillator, 400 kHz square wave from the system clock
`include "pmbc_cfg.svh"
module pmbc_boost_osc (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run,
  output logic sw
);
  localparam int DIV = `PMBC_BOOST_DIV;
  logic [8:0] cnt;

  // half-period counter; stops low in standby
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt <= 9'h000;
      sw <= 1'b0;
    end
    else if (!run)
    begin
      cnt <= 9'h000;
      sw <= 1'b0;
    end
    else if (cnt == 9'(DIV - 1))
    begin
      cnt <= 9'h000;
      sw <= ~sw;
    end
    else
      cnt <= cnt + 9'h001;
  end
endmodule

// ---- test/pmbc_monitor.sv ----
// concurrent checks on the power mode and boost controller ports
module pmbc_monitor
  import pmbc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic [7:0] gpio_out,
  input wire logic [7:0] res_enable,
  input wire logic [7:0] res_clk_en,
  input wire pmbc_pkg::pmbc_mode_t power_mode,
  input wire logic boost_active,
  input wire logic [5:0] boost_vsel,
  input wire logic boost_sw,
  input wire logic timewheel_irq
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////////
  // mode and resource relations
  a_mode_onehot: assert property ($onehot(power_mode))
    else $error("power mode not one-hot");
  a_clk_gated: assert property ((res_clk_en & ~res_enable) == 8'h00)
    else $error("clock runs for a disabled resource");
  a_sleep_mask: assert property (power_mode == PMBC_MODE_SLEEP [*2] |->
    (res_enable & 8'h7f) == 8'h00) else $error("resource left on in sleep");
  a_hib_hold: assert property (power_mode == PMBC_MODE_HIB [*2] |-> $stable(gpio_out))
    else $error("output pins moved in hibernate");
  // leaving a low power mode always brings the processor back
  a_wake_cpu: assert property (power_mode == PMBC_MODE_ACTIVE &&
    ($past(power_mode) == PMBC_MODE_SLEEP || $past(power_mode) == PMBC_MODE_HIB)
    |-> ##[0:2] res_enable[0]) else $error("processor not enabled on wake");
  ////////////////////////////////////////////////////////////////////////////////
  // boost, timewheel and read port
  a_standby_quiet: assert property (!boost_active [*3] |-> !boost_sw)
    else $error("boost switching in standby");
  // a drop into standby may cut a half period short, that is not a fault
  a_sw_half: assert property ($changed(boost_sw) && boost_active |=>
    (!boost_active || $stable(boost_sw)) [*8]) else $error("boost half period too short");
  a_vsel_max: assert property (boost_vsel <= 6'h20)
    else $error("boost code above 5.0 V");
  a_tw_single: assert property (timewheel_irq |=> !timewheel_irq)
    else $error("timewheel pulse longer than one cycle");
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data outside its cycle");
  c_hib_wake: cover property (power_mode == PMBC_MODE_HIB ##1 power_mode == PMBC_MODE_ACTIVE);
  c_sleep_wake: cover property (power_mode == PMBC_MODE_SLEEP ##1 power_mode == PMBC_MODE_ACTIVE);
  c_tw_pulse: cover property (timewheel_irq);
endmodule
bind pmbc_top pmbc_monitor pmbc_monitor_inst (.clk, .rst_n, .reg_rd, .reg_rdata, .gpio_out,
  .res_enable, .res_clk_en, .power_mode, .boost_active, .boost_vsel, .boost_sw, .timewheel_irq);

// ---- test/tb.sv ----
// self-checking bench for the power mode and boost controller
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import pmbc_pkg::*;
  logic clk, rst_n, reg_wr, reg_rd, boost_active, boost_sw, timewheel_irq;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata;
  logic [5:0] src, boost_vsel;
  logic [7:0] gpio_out_in, gpio_out, res_enable, res_clk_en;
  pmbc_mode_t power_mode;
  int bad_count = 0;
  int check_count = 0;
  int tw_count = 0;
  int n, i;
  logic [15:0] rst_tbl [0:7];
  pmbc_top pmbc_top_inst (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .periph_irq(src[0]), .supervisor_irq(src[1]), .pin_irq(src[2]),
    .watchdog_reset_source(src[3]), .precise_low_voltage_reset(src[4]),
    .external_reset_pin_n(~src[5]), .gpio_out_in, .gpio_out, .res_enable, .res_clk_en,
    .power_mode, .boost_active, .boost_vsel, .boost_sw, .timewheel_irq);
  ////////////////////////////////////////////////////////////////////////////////
  // clock, pulse counter and watchdog
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) tw_count <= tw_count + int'(timewheel_irq);
  // longest path is eight sleep resumes plus one hibernate resume
  initial
  begin
    repeat (60000) @(posedge clk);
    bad_count++;
    $display("ERROR %0t: timeout", $time);
    wrap_up;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // shared tasks
  task chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    bad_count += int'(got !== exp);
    if (got !== exp) $display("ERROR %0t: got %h expected %h", $time, got, exp);
  endtask
  task settle(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask
  // sources are levels, so hold them past the two-flop sync
  task pulse(input int k);
    @(posedge clk);
    src[k] <= 1'b1;
    repeat (4) @(posedge clk);
    src[k] <= 1'b0;
  endtask
  task wait_active;
    for (n = 0; power_mode !== PMBC_MODE_ACTIVE && n < 30000; n++) settle(1);
  endtask
  task sleep_wake(input int k, input int lo, input int hi);
    wr(4'h0, 16'h0002);
    settle(2);
    chk(16'(power_mode), 16'(PMBC_MODE_SLEEP));
    chk(16'(res_enable), 16'h0080);
    // timewheel is enabled only once asleep, so it cannot swallow the mode write
    if (k < 6)
      pulse(k);
    else
      wr(4'h3, 16'h0008);
    wait_active;
    chk(16'(n > lo && n < hi), 16'h0001);
    settle(2);
    chk(16'(res_enable[0]), 16'h0001);
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    rst_n = 1'b0;
    {reg_wr, reg_rd, reg_addr, reg_wdata, src, gpio_out_in} = '0;
    rst_tbl = '{16'h0001, 16'h00ff, 16'h00fe, 16'h000f, 16'h0000, 16'h00ff, 16'h0fff, 16'h0000};
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    settle(6);
    for (i = 0; i < 8; i++) rd(i[3:0], rst_tbl[i]);
    $display("reset values done");
    wr(4'h1, 16'h005a);
    settle(2);
    chk(16'(res_enable), 16'h005a);
    chk(16'(res_clk_en), 16'h005a);
    wr(4'h1, 16'h00fe);
    settle(2);
    chk(16'(res_enable[0]), 16'h0000);
    pulse(1);
    settle(6);
    chk(16'(res_enable), 16'h00ff);
    rd(4'h1, 16'h00ff);
    wr(4'h2, 16'h003c);
    wr(4'h0, 16'h0001);
    settle(2);
    chk(16'(power_mode), 16'(PMBC_MODE_ALT));
    chk(16'(res_enable), 16'h003c);
    pulse(0);
    settle(4);
    chk(16'(power_mode), 16'(PMBC_MODE_ACTIVE));
    chk(16'(res_enable), 16'h00ff);
    $display("templates done");
    wr(4'h4, 16'h003f);
    settle(2);
    chk(16'(boost_vsel), 16'h0020);
    wr(4'h3, 16'h0000);
    wr(4'h0, 16'h0002);
    wr(4'h4, 16'h0105);
    rd(4'h4, 16'h0105);
    chk(16'(boost_active), 16'h0000);
    settle(600);
    wr(4'h4, 16'h0000);
    for (n = 0; boost_sw !== 1'b1 && n < 600; n++) settle(1);
    for (n = 0; boost_sw === 1'b1 && n < 600; n++) settle(1);
    chk(16'(n), 16'd250);
    chk(16'(boost_active), 16'h0001);
    pulse(5);
    wait_active;
    chk(16'(n > 2980 && n < 3020), 16'h0001);
    wr(4'h3, 16'h000f);
    $display("boost done");
    wr(4'h6, 16'h0020);
    i = tw_count;
    settle(340);
    chk(16'(tw_count - i inside {[9:11]}), 16'h0001);
    wr(4'h3, 16'h0000);
    sleep_wake(6, 2990, 3100);
    wr(4'h3, 16'h0007);
    $display("timewheel done");
    @(posedge clk);
    gpio_out_in <= 8'ha5;
    settle(3);
    chk(16'(gpio_out), 16'h00a5);
    wr(4'h0, 16'h0003);
    settle(2);
    chk(16'(power_mode), 16'(PMBC_MODE_HIB));
    @(posedge clk);
    gpio_out_in <= 8'h5a;
    pulse(0);
    settle(20);
    chk(16'(power_mode), 16'(PMBC_MODE_HIB));
    chk(16'(gpio_out), 16'h00a5);
    // pin interrupt held as a level, one edge only while hibernating
    @(posedge clk);
    src[2] <= 1'b1;
    settle(3);
    wait_active;
    chk(16'(n > 19900 && n < 20000), 16'h0001);
    @(posedge clk);
    src[2] <= 1'b0;
    settle(3);
    chk(16'(gpio_out), 16'h005a);
    $display("hibernate done");
    for (i = 0; i < 6; i++) sleep_wake(i, 2980, 3020);
    $display("sleep wakes done");
    wrap_up;
  end
endmodule
